// ===== dsx_buc_model.sv
// dsx_buc_model: bus unit controller that ends each direct-store access
// assumes: dly_i set before the access, zero answers at once
`timescale 1ns/1ns
module dsx_buc_model (
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  input  wire logic       active_i,
  input  wire logic [3:0] dly_i,
  output logic            done_o
);
  logic [3:0] cnt_reg;
  // end the access once it has stood dly_i cycles
  assign done_o = active_i && (cnt_reg == dly_i);
  // count cycles of the current access
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) cnt_reg <= 4'h0;
    else cnt_reg <= done_o ? 4'h0 : cnt_reg + {3'h0, active_i};
  end
endmodule

// ===== dsx_irq_gate.sv
// dsx_irq_gate: fixed-latency path from the active-low irq pin to its gate
// assumes: irq pin already synchronous to clk_sys_i
`timescale 1ns/1ns
module dsx_irq_gate
  import dsx_pkg::*;
#(
  parameter int LAT = DSX_IRQ_LAT_CYC
) (
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  input  wire logic irq_req_n_i,
  input  wire logic irq_mask_i,
  output logic      irq_take_o
);

  initial begin
    if (LAT < 1) $error("dsx_irq_gate: LAT must be at least 1");
  end

  logic [LAT-1:0] pipe_reg;
  logic [LAT-1:0] pipe_next;

  // shift the request down a fixed pipeline, active high inside
  always_comb begin
    pipe_next = LAT'({pipe_reg, ~irq_req_n_i}); // oldest stage drops off the top
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pipe_reg <= '0;
    end else begin
      pipe_reg <= pipe_next;
    end
  end

  // gate with the enable exactly LAT cycles after the pin
  assign irq_take_o = pipe_reg[LAT-1] & irq_mask_i;

endmodule

// ===== dsx_pkg.sv
// dsx_pkg: register offsets, segment field layout, reset values and timing
// assumes: big-endian bit numbering of the segment word, bit 0 is the msb
package dsx_pkg;

  // register byte offsets on the apb
  localparam logic [7:0] DSX_SEG_OFF    = 8'h00; // segment_descriptor
  localparam logic [7:0] DSX_CTRL_OFF   = 8'h04; // privilege / irq enable control
  localparam logic [7:0] DSX_STAT_OFF   = 8'h08; // access and irq state
  localparam logic [7:0] DSX_LAT_OFF    = 8'h0C; // irq gating latency, read only

  // segment word fields, given as lsb index of a 32-bit vector (sr bit n = 31-n)
  localparam int DSX_T_POS      = 31;  // sr bit 0
  localparam int DSX_KS_POS     = 30;  // sr bit 1
  localparam int DSX_KP_POS     = 29;  // sr bit 2
  localparam int DSX_BUS_UNIT_ID_LSB   = 20;  // sr bits 3..11
  localparam int DSX_BUS_UNIT_ID_W     = 9;
  localparam int DSX_OLDA_LSB   = 18;  // sr bits 12..13
  localparam int DSX_NEWA_LSB   = 15;  // sr bits 14..16
  localparam int DSX_AMASK_LSB  = 8;   // sr bits 17..23
  localparam int DSX_AMASK_W    = 7;
  localparam int DSX_ALT_POS    = 7;   // sr bit 24
  localparam int DSX_OLDB_LSB   = 5;   // sr bits 25..26
  localparam int DSX_NEWB_POS   = 4;   // sr bit 27
  localparam int DSX_EXT_LSB    = 0;   // sr bits 28..31
  localparam int DSX_EXT_W      = 4;
  localparam int DSX_EA_LOW_W   = 28;

  // control register fields
  localparam int DSX_CTRL_PRIV_POS  = 0;  // 1 = privileged state
  localparam int DSX_CTRL_IRQEN_POS = 1;  // async_irq_mask_bit

  // reset values
  localparam logic [31:0] DSX_SEG_RST  = 32'h0000_0000;
  localparam logic [1:0]  DSX_CTRL_RST = 2'h0;

  // irq pin to gate latency
  localparam int DSX_IRQ_LAT_CYC = 2;

  // bus access states
  typedef enum logic [1:0] {
    DSX_IDLE,
    DSX_ACCESS,
    DSX_DONE
  } dsx_state_t;

endpackage

// ===== dsx_segment_export.sv
// dsx_segment_export: drives segment bits out during direct-store accesses
// assumes: apb slave, load/store strobes from the core, synchronous inputs
//
// Notes on behaviour
// - every required segment bit is driven out during each direct-store access.
// - one key bit is sent: supervisor key if privileged, else user key.
// - the full nine-bit bus unit id is driven during direct-store access.
// - authority mask and alternate space bit are driven every direct-store access.
// - io address is address extent above the low 28 effective address bits.
// - segment register reads back exactly what was written, all bits.
// - with few pins, newer optional bits are preferred over older ones.
// - irq pin to enable gate has a fixed stated latency.
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module dsx_segment_export
  import dsx_pkg::*;
#(
  parameter int OPT_PINS = 4  // optional bit pins available, 0..9
) (
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  // apb
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // core side access request
  input  wire logic        acc_start_i,
  input  wire logic [31:0] eff_addr_i,
  input  wire logic        acc_done_i,
  input  wire logic        irq_req_n_i,
  // bus unit controller side
  output logic             acc_active_o,
  output logic             direct_store_o,
  output logic             key_o,
  output logic [8:0]       bus_unit_id_o,
  output logic [6:0]       auth_mask_o,
  output logic             alt_space_o,
  output logic [31:0]      io_addr_o,
  output logic [8:0]       opt_bits_o,
  output logic             irq_take_o
);

  initial begin
    if (OPT_PINS < 0 || OPT_PINS > 9) $error("dsx_segment_export: OPT_PINS out of range");
  end

  // register state
  logic [31:0] seg_reg;
  logic [31:0] seg_next;
  logic [1:0]  ctrl_reg;
  logic [1:0]  ctrl_next;

  // apb decode
  logic wr_en;
  logic rd_hit;
  assign wr_en     = psel_i & penable_i & pwrite_i;
  assign pready_o  = 1'b1;
  assign rd_hit    = (paddr_i == DSX_SEG_OFF) | (paddr_i == DSX_CTRL_OFF) |
                     (paddr_i == DSX_STAT_OFF) | (paddr_i == DSX_LAT_OFF);
  assign pslverr_o = psel_i & penable_i & ~rd_hit;

  // register writes, whole segment word kept, control keeps only bits 1..0
  always_comb begin
    seg_next  = seg_reg;
    ctrl_next = ctrl_reg;
    if (wr_en && paddr_i == DSX_SEG_OFF) seg_next = pwdata_i;
    if (wr_en && paddr_i == DSX_CTRL_OFF) ctrl_next = pwdata_i[1:0];
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      seg_reg  <= DSX_SEG_RST;
      ctrl_reg <= DSX_CTRL_RST;
    end else begin
      seg_reg  <= seg_next;
      ctrl_reg <= ctrl_next;
    end
  end

  // access state machine and snapshot of exported bits
  dsx_state_t  state_reg;
  dsx_state_t  state_next;
  logic [31:0] snap_reg;
  logic [31:0] snap_next;
  logic [31:0] ea_reg;
  logic [31:0] ea_next;
  logic        priv_reg;
  logic        priv_next;

  always_comb begin
    state_next = state_reg;
    snap_next  = snap_reg;
    ea_next    = ea_reg;
    priv_next  = priv_reg;
    case (state_reg)
      DSX_IDLE: begin
        if (acc_start_i) begin
          snap_next  = seg_reg;
          ea_next    = eff_addr_i;
          priv_next  = ctrl_reg[DSX_CTRL_PRIV_POS];
          state_next = DSX_ACCESS;
        end
      end
      DSX_ACCESS: begin
        if (acc_done_i) state_next = DSX_DONE;
      end
      DSX_DONE: begin
        state_next = DSX_IDLE;
      end
      default: begin
        state_next = DSX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= DSX_IDLE;
      snap_reg  <= DSX_SEG_RST;
      ea_reg    <= 32'h0000_0000;
      priv_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      snap_reg  <= snap_next;
      ea_reg    <= ea_next;
      priv_reg  <= priv_next;
    end
  end

  // optional bits, newer ones first: 14..16, 27, then 12..13, 25..26
  function automatic logic [8:0] opt_order(input logic [31:0] s, input int n);
    logic [8:0] all;
    logic [8:0] m;
    all = {s[DSX_NEWA_LSB+2], s[DSX_NEWA_LSB+1], s[DSX_NEWA_LSB], s[DSX_NEWB_POS],
           s[DSX_OLDA_LSB+1], s[DSX_OLDA_LSB], s[DSX_OLDB_LSB+1], s[DSX_OLDB_LSB], 1'b0};
    m   = 9'h000;
    for (int i = 0; i < 9; i++) begin
      if (i < n) m[8-i] = 1'b1;
    end
    return all & m;
  endfunction

  // exported fields, driven from the snapshot so they hold all access long
  logic active;
  assign active = (state_reg == DSX_ACCESS);
  always_comb begin
    acc_active_o   = active;
    direct_store_o = active & snap_reg[DSX_T_POS];
    key_o          = priv_reg ? snap_reg[DSX_KS_POS] : snap_reg[DSX_KP_POS];
    bus_unit_id_o  = snap_reg[DSX_BUS_UNIT_ID_LSB +: DSX_BUS_UNIT_ID_W];
    auth_mask_o    = snap_reg[DSX_AMASK_LSB +: DSX_AMASK_W];
    alt_space_o    = snap_reg[DSX_ALT_POS];
    io_addr_o      = {snap_reg[DSX_EXT_LSB +: DSX_EXT_W],
                      ea_reg[DSX_EA_LOW_W-1:0]};
    opt_bits_o     = opt_order(snap_reg, OPT_PINS);
    if (!active) begin
      key_o         = 1'b0;
      bus_unit_id_o = 9'h000;
      auth_mask_o   = 7'h00;
      alt_space_o   = 1'b0;
      io_addr_o     = 32'h0000_0000;
      opt_bits_o    = 9'h000;
    end
  end

  // fixed latency irq gating
  dsx_irq_gate #(
    .LAT (DSX_IRQ_LAT_CYC)
  ) u_irq (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .irq_req_n_i (irq_req_n_i),
    .irq_mask_i  (ctrl_reg[DSX_CTRL_IRQEN_POS]),
    .irq_take_o  (irq_take_o)
  );

  // read mux
  always_comb begin
    prdata_o = 32'h0000_0000;
    case (paddr_i)
      DSX_SEG_OFF:  prdata_o = seg_reg;
      DSX_CTRL_OFF: prdata_o = {30'h0000_0000, ctrl_reg};
      DSX_STAT_OFF: prdata_o = {29'h0000_0000, irq_take_o, direct_store_o, active};
      DSX_LAT_OFF:  prdata_o = 32'(DSX_IRQ_LAT_CYC);
      default:      prdata_o = 32'h0000_0000;
    endcase
  end

endmodule

// ===== dsx_segment_export_monitor.sv
// dsx_segment_export_monitor: port checks of the segment export block
// assumes: bound to dsx_segment_export, one clock domain
`timescale 1ns/1ns
module dsx_segment_export_monitor
  import dsx_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        sys_rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        acc_start_i,
  input wire logic [31:0] eff_addr_i,
  input wire logic        irq_req_n_i,
  input wire logic        acc_active_o,
  input wire logic        direct_store_o,
  input wire logic        key_o,
  input wire logic [8:0]  bus_unit_id_o,
  input wire logic [6:0]  auth_mask_o,
  input wire logic        alt_space_o,
  input wire logic [31:0] io_addr_o,
  input wire logic        irq_take_o
);
  logic [32:0] sh_reg;
  logic [32:0] sh_next;
  wire         wr_w = psel_i && penable_i && pwrite_i;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // shadow of privilege bit and segment word
  always_comb begin
    sh_next = sh_reg;
    if (wr_w && paddr_i == DSX_SEG_OFF) sh_next[31:0] = pwdata_i;
    if (wr_w && paddr_i == DSX_CTRL_OFF) sh_next[32] = pwdata_i[DSX_CTRL_PRIV_POS];
  end
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) sh_reg <= {1'b0, DSX_SEG_RST};
    else sh_reg <= sh_next;
  end
  // exports at the first active cycle come from the state at the start
  property p_start; $rose(acc_active_o) |-> $past(acc_start_i); endproperty
  a_start: assert property (p_start) else $error("access without start");
  property p_type; $rose(acc_active_o) |-> direct_store_o == $past(sh_reg[DSX_T_POS]); endproperty
  a_type: assert property (p_type) else $error("access type wrong");
  property p_key; $rose(acc_active_o) |-> key_o == ($past(sh_reg[32]) ?
    $past(sh_reg[DSX_KS_POS]) : $past(sh_reg[DSX_KP_POS])); endproperty
  a_key: assert property (p_key) else $error("key wrong");
  property p_bus_unit_id; $rose(acc_active_o) |-> bus_unit_id_o == $past(sh_reg[28:20]); endproperty
  a_bus_unit_id: assert property (p_bus_unit_id) else $error("bus unit id wrong");
  property p_mask; $rose(acc_active_o) |-> {auth_mask_o, alt_space_o} == $past(sh_reg[14:7]);
  endproperty
  a_mask: assert property (p_mask) else $error("mask or alt wrong");
  property p_addr; $rose(acc_active_o) |->
    io_addr_o == {$past(sh_reg[3:0]), $past(eff_addr_i[27:0])}; endproperty
  a_addr: assert property (p_addr) else $error("io address wrong");
  property p_hold; acc_active_o && $past(acc_active_o) |->
    $stable({direct_store_o, key_o, bus_unit_id_o, auth_mask_o, alt_space_o, io_addr_o});
  endproperty
  a_hold: assert property (p_hold) else $error("exports moved");
  property p_irq; irq_take_o |-> !$past(irq_req_n_i, 2); endproperty
  a_irq: assert property (p_irq) else $error("irq latency wrong");
endmodule
bind dsx_segment_export dsx_segment_export_monitor u_mon (.*);

// ===== dsx_segment_export_tb_top.sv
// dsx_segment_export_tb_top: self-checking bench of the segment export block
// assumes: 10 MHz clock, apb master tasks, controller model ends accesses
`timescale 1ns/1ns
module dsx_segment_export_tb_top
  import dsx_pkg::*;
;
  logic        clk_sys_i = 1'b0, sys_rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
  logic        pwrite_i = 1'b0, acc_start_i = 1'b0, irq_req_n_i = 1'b1, acc_done_i, err;
  logic        pready_o, pslverr_o, acc_active_o, direct_store_o, key_o, alt_space_o;
  logic        irq_take_o;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, eff_addr_i = 32'h0, prdata_o, io_addr_o, q, s;
  logic [8:0]  bus_unit_id_o, opt_bits_o;
  logic [6:0]  auth_mask_o;
  logic [3:0]  dly = 4'h0;
  int          fails = 0, cmp_count = 0, cyc = 0;
  typedef struct packed {logic [31:0] seg, ea, io; logic priv, key; logic [3:0] dly;} dsx_row_t;
  dsx_row_t    rows [4] = '{
    '{32'hDEAD_BEEF, 32'h1234_5678, 32'hF234_5678, 1'b1, 1'b1, 4'h0},
    '{32'hA5A5_5A5A, 32'hFFFF_FFFF, 32'hAFFF_FFFF, 1'b1, 1'b0, 4'h5},
    '{32'h3000_0001, 32'h0000_0000, 32'h1000_0000, 1'b0, 1'b1, 4'h1},
    '{32'h4000_0000, 32'h9ABC_DEF0, 32'h0ABC_DEF0, 1'b0, 1'b0, 4'h3}};
  dsx_segment_export dut (.*);
  dsx_buc_model u_buc (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .active_i(acc_active_o),
    .dly_i(dly), .done_o(acc_done_i));
  // clock and hang guard
  always #50 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
    cmp_count++;
    if (v !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, v);
    end
  endtask
  // one apb transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    q = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  // start an access, stop in its first active cycle
  task automatic acc(input logic [31:0] ea);
    acc_start_i <= 1'b1;
    eff_addr_i <= ea;
    @(posedge clk_sys_i);
    acc_start_i <= 1'b0;
    @(negedge clk_sys_i);
  endtask
  task automatic idle();
    while (acc_active_o) @(negedge clk_sys_i);
    repeat (2) @(posedge clk_sys_i);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    apb(1'b0, DSX_SEG_OFF, 32'h0);
    chk("seg reset", DSX_SEG_RST, q);
    foreach (rows[i]) begin
      s = rows[i].seg;
      dly <= rows[i].dly;
      apb(1'b1, DSX_SEG_OFF, s);
      apb(1'b1, DSX_CTRL_OFF, {31'h0, rows[i].priv});
      apb(1'b0, DSX_SEG_OFF, 32'h0);
      chk("readback", s, q);
      acc(rows[i].ea);
      chk("io_addr", rows[i].io, io_addr_o);
      chk("fields", {13'h0, s[DSX_T_POS], rows[i].key, s[28:20], s[14:8], s[DSX_ALT_POS]},
        {13'h0, direct_store_o, key_o, bus_unit_id_o, auth_mask_o, alt_space_o});
      chk("opt", {23'h0, s[17:15], s[DSX_NEWB_POS], 5'h0}, {23'h0, opt_bits_o});
      idle();
    end
    // segment rewritten during a slow access must not reach the exports
    dly <= 4'h8;
    acc(32'h1111_1111);
    @(posedge clk_sys_i);
    apb(1'b1, DSX_SEG_OFF, 32'hFFFF_FFFF);
    apb(1'b0, DSX_STAT_OFF, 32'h0);
    chk("stat active", 32'h1, q);
    @(negedge clk_sys_i);
    chk("held io_addr", 32'h0111_1111, io_addr_o);
    idle();
    apb(1'b0, DSX_SEG_OFF, 32'h0);
    chk("all bits", 32'hFFFF_FFFF, q);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h8000_0000, {err, q[30:0]});
    apb(1'b0, DSX_LAT_OFF, 32'h0);
    chk("latency", 32'(DSX_IRQ_LAT_CYC), q);
    apb(1'b1, DSX_CTRL_OFF, 32'h2);
    irq_req_n_i <= 1'b0;
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk("irq early", 32'h0, {31'h0, irq_take_o});
    @(negedge clk_sys_i);
    chk("irq taken", 32'h1, {31'h0, irq_take_o});
    @(posedge clk_sys_i);
    apb(1'b1, DSX_CTRL_OFF, 32'h0);
    @(negedge clk_sys_i);
    chk("irq masked", 32'h0, {31'h0, irq_take_o});
    print_verdict();
  end
endmodule
